/* File: design/usb_xcvr_termination_ctrl.sv */
// Transceiver control: registers, termination enables, receive select and transmit path
`include "xcvr_map.svh"
module usb_xcvr_termination_ctrl
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	output logic             dp_pullup_enable,
	output logic             dm_pullup_enable,
	output logic             dp_pulldown_enable,
	output logic             dm_pulldown_enable,
	output logic             hs_termination_enable,
	output logic [2:0]       tx_amplitude_boost,
	output logic [2:0]       squelch_sensitivity,
	input  wire logic        hs_rx_bit,
	input  wire logic        fs_rx_bit,
	input  wire logic        hs_squelch,
	input  wire logic        dp_se_rx,
	input  wire logic        dm_se_rx,
	output logic             rx_bit,
	output logic             rx_valid,
	output logic [1:0]       line_state,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic             hs_tx_bit,
	output logic             hs_tx_oe,
	output logic             fs_tx_dp,
	output logic             fs_tx_dm,
	output logic             fs_tx_oe
);
	logic [1:0]          xcvr_select_r;
	logic                term_select_r;
	logic [1:0]          op_mode_r;
	logic                dp_pd_req_r;
	logic                dm_pd_req_r;
	logic [2:0]          boost_r;
	logic [2:0]          sense_r;
	xcvr_pkg::term_vec_t term_en_nxt;
	xcvr_pkg::term_vec_t term_en_r;
	logic                ack_r;
	logic                req;
	logic                wr_go;
	logic [31:0]         readdata_r;
	logic [31:0]         rd_mux;
	logic                rx_bit_r;
	logic                rx_valid_r;
	logic                squelch_r;
	logic [1:0]          line_r;
	logic                ser_bit;
	logic                ser_active;
	logic                hs_mode;
	logic                drive_ok;
	logic                hs_bit_r;
	logic                fs_dp_r;
	logic                fs_dm_r;
	logic                hs_oe_r;
	logic                fs_oe_r;

	// Avalon slave: one wait cycle, then the answer; read data is latched in the wait cycle
	assign req         = read || write;
	assign waitrequest = req && !ack_r;
	assign wr_go       = write && ack_r;
	assign readdata    = readdata_r;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= req && !ack_r;
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (address)
			`FUNC_CTRL_OFS:
			begin
				rd_mux[`XS_LSB +: 2] = xcvr_select_r;
				rd_mux[`TS_BIT]      = term_select_r;
				rd_mux[`OP_LSB +: 2] = op_mode_r;
			end
			`OTG_CTRL_OFS:
			begin
				rd_mux[`DP_PD_BIT] = dp_pd_req_r;
				rd_mux[`DM_PD_BIT] = dm_pd_req_r;
			end
			`HS_COMP_OFS:
			begin
				rd_mux[`BOOST_LSB +: 3] = boost_r;
				rd_mux[`SENSE_LSB +: 3] = sense_r;
			end
			`STATUS_OFS:
			begin
				rd_mux[4:0]              = term_en_r;
				rd_mux[`LINE_LSB +: 2]   = line_r;
				rd_mux[`SQUELCH_BIT]     = squelch_r;
				rd_mux[`RXVALID_BIT]     = rx_valid_r;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			readdata_r <= 32'h0000_0000;
		else if (read && !ack_r)
			readdata_r <= rd_mux;
	end

	// Reset values are the power-up termination setting
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			xcvr_select_r <= `XS_RST;
			term_select_r <= `TS_RST;
			op_mode_r     <= `OP_RST;
		end
		else if (wr_go && address == `FUNC_CTRL_OFS)
		begin
			xcvr_select_r <= writedata[`XS_LSB +: 2];
			term_select_r <= writedata[`TS_BIT];
			op_mode_r     <= writedata[`OP_LSB +: 2];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dp_pd_req_r <= `PD_RST;
			dm_pd_req_r <= `PD_RST;
		end
		else if (wr_go && address == `OTG_CTRL_OFS)
		begin
			dp_pd_req_r <= writedata[`DP_PD_BIT];
			dm_pd_req_r <= writedata[`DM_PD_BIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			boost_r <= `BOOST_RST;
			sense_r <= `SENSE_RST;
		end
		else if (wr_go && address == `HS_COMP_OFS)
		begin
			boost_r <= writedata[`BOOST_LSB +: 3];
			sense_r <= writedata[`SENSE_LSB +: 3];
		end
	end

	assign tx_amplitude_boost  = boost_r;
	assign squelch_sensitivity = sense_r;

	term_decode u_term_decode
	(
		.xcvr_select (xcvr_select_r),
		.term_select (term_select_r),
		.op_mode     (op_mode_r),
		.dp_pulldown (dp_pd_req_r),
		.dm_pulldown (dm_pd_req_r),
		.term_en     (term_en_nxt)
	);

	// Enables open all-off through reset, then track the decode one cycle behind
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			term_en_r <= 5'h00;
		else
			term_en_r <= term_en_nxt;
	end

	assign dp_pullup_enable      = term_en_r[4];
	assign dm_pullup_enable      = term_en_r[3];
	assign dp_pulldown_enable    = term_en_r[2];
	assign dm_pulldown_enable    = term_en_r[1];
	assign hs_termination_enable = term_en_r[0];

	assign hs_mode  = (xcvr_select_r == `XS_HS);
	assign drive_ok = (op_mode_r != `OP_NODRIVE);

	// Receive path; squelch holds off HS data so line noise never looks like a packet
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rx_bit_r   <= 1'b0;
			rx_valid_r <= 1'b0;
			squelch_r  <= 1'b1;
			line_r     <= 2'h0;
		end
		else
		begin
			rx_bit_r   <= hs_mode ? hs_rx_bit : fs_rx_bit;
			rx_valid_r <= hs_mode ? !hs_squelch : 1'b1;
			squelch_r  <= hs_squelch;
			line_r     <= {dm_se_rx, dp_se_rx};
		end
	end

	assign rx_bit     = rx_bit_r;
	assign rx_valid   = rx_valid_r;
	assign line_state = line_r;

	tx_serializer u_tx_serializer
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.data_in    (tx_data),
		.valid_in   (tx_valid),
		.ready_out  (tx_ready),
		.bit_out    (ser_bit),
		.active_out (ser_active)
	);

	// Serial bit steered to the HS or FS/LS driver by speed mode
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			hs_bit_r <= 1'b0;
			fs_dp_r  <= 1'b1;
			fs_dm_r  <= 1'b0;
			hs_oe_r  <= 1'b0;
			fs_oe_r  <= 1'b0;
		end
		else
		begin
			hs_bit_r <= ser_bit;
			fs_dp_r  <= ser_bit;
			fs_dm_r  <= !ser_bit;
			hs_oe_r  <= ser_active && hs_mode && drive_ok;
			fs_oe_r  <= ser_active && !hs_mode && drive_ok;
		end
	end

	// Gated straight by reset so drivers are off even before the first edge
	assign hs_tx_oe  = hs_oe_r && rst_n;
	assign fs_tx_oe  = fs_oe_r && rst_n;
	assign hs_tx_bit = hs_bit_r;
	assign fs_tx_dp  = fs_dp_r;
	assign fs_tx_dm  = fs_dm_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_nodrive_all_off: assert property (
		op_mode_r == `OP_NODRIVE |=> term_en_r == 5'h00 && !hs_tx_oe && !fs_tx_oe)
		else $error("termination active in non-driving mode");
	// Sampled rst_n gates the release edge, where the enables are still held off
	a_pulldown_follows: assert property (
		(rst_n && op_mode_r != `OP_NODRIVE && dp_pd_req_r && dm_pd_req_r)
			|=> dp_pulldown_enable && dm_pulldown_enable && !dp_pullup_enable)
		else $error("pull-downs not following request");
	a_dp_pullup_cause: assert property (
		dp_pullup_enable |-> $past(term_select_r && !xcvr_select_r[1] && !dp_pd_req_r))
		else $error("dp pull-up without cause");
	a_dm_pullup_cause: assert property (
		dm_pullup_enable |-> $past(term_select_r && xcvr_select_r == 2'h2
			&& !dp_pd_req_r && !dm_pd_req_r))
		else $error("dm pull-up without cause");
	a_hsterm_cause: assert property (
		hs_termination_enable |-> $past(xcvr_select_r == `XS_HS && !term_select_r
			&& !op_mode_r[0]))
		else $error("hs termination without cause");
	a_otg_chirp_mix: assert property (
		(xcvr_select_r == `XS_HS && term_select_r && op_mode_r == 2'h2
			&& !dp_pd_req_r && dm_pd_req_r)
			|=> term_en_r == 5'h12)
		else $error("otg chirp enables wrong");
	a_undefined_fallback: assert property (
		(xcvr_select_r == 2'h3 && !term_select_r && op_mode_r == 2'h0)
			|=> term_en_r == 5'h06)
		else $error("undefined setting not falling back");
	a_reset_tristate: assert property (
		@(posedge clk) disable iff (1'b0) !rst_n |-> !hs_tx_oe && !fs_tx_oe)
		else $error("driver enabled during reset");
	a_squelch_gates: assert property (
		hs_mode && hs_squelch |=> !rx_valid)
		else $error("squelched data marked valid");
	a_rx_mux_select: assert property (
		rst_n && !hs_mode |=> rx_bit == $past(fs_rx_bit) && rx_valid)
		else $error("fs receive bit not selected");
	a_tx_drives_once: assert property (
		tx_valid && tx_ready && !ser_active |-> ##3 (hs_tx_oe || fs_tx_oe || !drive_ok))
		else $error("transmit did not start");

	c_host_chirp: cover property (term_en_r == 5'h07);
	c_periph_fs: cover property (term_en_r == 5'h10 || term_en_r == 5'h08);
	c_otg_hs: cover property (term_en_r == 5'h03);
	c_tx_burst: cover property (tx_valid && tx_ready ##[1:12] (tx_valid && tx_ready));
endmodule : usb_xcvr_termination_ctrl

/* File: design/xcvr_map.svh */
// Register offsets, field positions, reset values and timing counts of the transceiver control
// Contract
// - Termination enables come only from five control fields
// - Termination state follows the configured operating mode
// - Non-driving mode turns every termination off
// - Pull-downs follow their request bits when defined
// - DP pull-up: term select, FS/HS, no DP pull-down
// - DM pull-up only for low-speed peripheral
// - HS termination: HS select, term off, normal/chirp
// - OTG peripheral adds DM pull-down to peripheral setup
// - Undefined settings: both pull-downs, nothing else
// - Line drivers tri-stated while reset is low
// - Receive bit chosen from HS or FS receiver
// - HS receive data gated by squelch
// - FS line state from two single-ended receivers
// - Transmit: encode, bit stuff, serialize, drive
// - Amplitude boost bits scale HS drive
// - Sensitivity bits lower HS squelch threshold
// - No upstream hub port termination settings
`ifndef XCVR_MAP_SVH
`define XCVR_MAP_SVH

`define FUNC_CTRL_OFS     4'h0
`define OTG_CTRL_OFS      4'h4
`define HS_COMP_OFS       4'h8
`define STATUS_OFS        4'hc

`define XS_LSB            0
`define TS_BIT            2
`define OP_LSB            3
`define DP_PD_BIT         0
`define DM_PD_BIT         1
`define BOOST_LSB         0
`define SENSE_LSB         4
`define LINE_LSB          5
`define SQUELCH_BIT       7
`define RXVALID_BIT       8

`define XS_RST            2'h1
`define TS_RST            1'h0
`define OP_RST            2'h0
`define PD_RST            1'h1
`define BOOST_RST         3'h0
`define SENSE_RST         3'h0

`define XS_HS             2'h0
`define OP_NODRIVE        2'h1
`define STUFF_RUN         3'h6
`define LAST_BIT          3'h7

`endif

/* File: design/xcvr_pkg.sv */
// Types shared by the transceiver control modules
package xcvr_pkg;
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
	// Order of the termination enables: dp pull-up, dm pull-up, dp pull-down, dm pull-down, hs
	typedef logic [4:0] term_vec_t;
endpackage : xcvr_pkg

/* File: design/term_decode.sv */
// Decode of the five control fields into termination enables
module term_decode
(
	input  wire logic [1:0]         xcvr_select,
	input  wire logic               term_select,
	input  wire logic [1:0]         op_mode,
	input  wire logic               dp_pulldown,
	input  wire logic               dm_pulldown,
	output xcvr_pkg::term_vec_t     term_en
);
	always_comb
	begin
		// Only the listed control inputs reach this table
		casez ({xcvr_select, term_select, op_mode, dp_pulldown, dm_pulldown})
			7'b???01??: term_en = 5'h00;
			7'b0100011: term_en = 5'h06;
			7'b000?011: term_en = 5'h07;
			7'b?110011,
			7'b0111011,
			7'b101?011: term_en = 5'h06;          // host never pulls up
			7'b001100?,
			7'b011?00?: term_en = {4'h8, 1'b0} | {3'h0, dm_pulldown, 1'b0};
			7'b000?00?: term_en = {3'h0, dm_pulldown, 1'b1};
			7'b101?000: term_en = 5'h08;
			7'b0100001: term_en = 5'h02;
			// Hub-port and all other settings fall back here
			default:        term_en = 5'h06;
		endcase
	end
endmodule : term_decode

/* File: design/tx_serializer.sv */
// Byte serializer with bit stuffing and NRZI encoding
`include "xcvr_map.svh"
module tx_serializer
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] data_in,
	input  wire logic       valid_in,
	output logic            ready_out,
	output logic            bit_out,
	output logic            active_out
);
	xcvr_pkg::tx_state_t state_r;
	logic [7:0]          shift_r;
	logic [2:0]          cnt_r;
	logic [2:0]          ones_r;
	logic                nrzi_r;
	logic                active_r;
	logic                send;
	logic                stuff;
	logic                load;

	assign send      = (state_r == xcvr_pkg::TX_SEND);
	assign stuff     = send && (ones_r == `STUFF_RUN);
	assign ready_out = !send || (!stuff && cnt_r == `LAST_BIT);
	assign load      = valid_in && ready_out;
	assign bit_out    = nrzi_r;
	assign active_out = active_r;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_r <= xcvr_pkg::TX_IDLE;
		else
		begin
			unique case (state_r)
				xcvr_pkg::TX_IDLE: if (valid_in) state_r <= xcvr_pkg::TX_SEND;
				xcvr_pkg::TX_SEND: if (ready_out && !valid_in) state_r <= xcvr_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			shift_r <= 8'h00;
			cnt_r   <= 3'h0;
		end
		else if (load)
		begin
			shift_r <= data_in;
			cnt_r   <= 3'h0;
		end
		else if (send && !stuff)
		begin
			shift_r <= {1'b0, shift_r[7:1]};
			cnt_r   <= cnt_r + 3'h1;
		end
	end

	// Run of ones carries across byte boundaries so stuffing is exact
	always_ff @(posedge clk)
	begin
		if (!rst_n || !send || stuff)
			ones_r <= 3'h0;
		else if (shift_r[0])
			ones_r <= ones_r + 3'h1;
		else
			ones_r <= 3'h0;
	end

	// NRZI: a zero or a stuffed bit toggles the line, idle rests at J
	always_ff @(posedge clk)
	begin
		if (!rst_n || !send)
			nrzi_r <= 1'b1;
		else if (stuff || !shift_r[0])
			nrzi_r <= !nrzi_r;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			active_r <= 1'b0;
		else
			active_r <= send;
	end
endmodule : tx_serializer

/* File: sim/usb_peer.sv */
// Behavioural cable peer: drives the receivers and records the transmitted bits
module usb_peer
(
	input  wire logic clk,
	input  wire logic hs_tx_bit,
	input  wire logic hs_tx_oe,
	input  wire logic fs_tx_dp,
	input  wire logic fs_tx_oe,
	output logic      hs_rx_bit,
	output logic      fs_rx_bit,
	output logic      hs_squelch,
	output logic      dp_se_rx,
	output logic      dm_se_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r = 4'h0;
	logic       level_r = 1'b1;
	logic       line;
	logic       bits_q[$];
	// Walks all 16 counter values so each receiver differs from the others somewhere
	always @(posedge clk)
		cnt_r <= cnt_r + 4'h1;
	assign hs_rx_bit  = cnt_r[0];
	assign fs_rx_bit  = cnt_r[1];
	assign hs_squelch = cnt_r[2];
	assign dp_se_rx   = cnt_r[3];
	assign dm_se_rx   = cnt_r[3] ^ cnt_r[1];
	assign line       = hs_tx_oe ? hs_tx_bit : fs_tx_dp;
	// NRZI: an unchanged level is a one; the line is taken as J between frames
	always @(posedge clk)
	begin
		if (hs_tx_oe || fs_tx_oe)
			bits_q.push_back(line == level_r);
		level_r <= (hs_tx_oe || fs_tx_oe) ? line : 1'b1;
	end
endmodule : usb_peer

/* File: sim/tb.sv */
// Self-checking bench for the transceiver control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  address = 4'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [4:0]  term;
	logic [2:0]  boost;
	logic [2:0]  sense;
	logic        hs_rx_bit, fs_rx_bit, hs_squelch, dp_se_rx, dm_se_rx;
	logic        rx_bit, rx_valid, hs_tx_bit, hs_tx_oe, fs_tx_dp, fs_tx_dm, fs_tx_oe;
	logic [1:0]  line_state;
	logic [7:0]  tx_data = 8'h00;
	logic        tx_valid = 1'b0;
	logic        tx_ready;
	logic [31:0] q;
	int          fail_count = 0;
	int          checked = 0;
	int          cycles = 0;

	always #2 clk = ~clk;

	usb_xcvr_termination_ctrl dut
	(
		.clk, .rst_n, .address, .read, .write, .writedata, .readdata, .waitrequest,
		.dp_pullup_enable(term[4]), .dm_pullup_enable(term[3]),
		.dp_pulldown_enable(term[2]), .dm_pulldown_enable(term[1]),
		.hs_termination_enable(term[0]),
		.tx_amplitude_boost(boost), .squelch_sensitivity(sense),
		.hs_rx_bit, .fs_rx_bit, .hs_squelch, .dp_se_rx, .dm_se_rx,
		.rx_bit, .rx_valid, .line_state, .tx_data, .tx_valid, .tx_ready,
		.hs_tx_bit, .hs_tx_oe, .fs_tx_dp, .fs_tx_dm, .fs_tx_oe
	);

	usb_peer peer
	(
		.clk, .hs_tx_bit, .hs_tx_oe, .fs_tx_dp, .fs_tx_oe,
		.hs_rx_bit, .fs_rx_bit, .hs_squelch, .dp_se_rx, .dm_se_rx
	);

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// Whole run needs a few hundred cycles; anything longer is a hang
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			end_sim();
		end
	end

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	// Enables follow one edge after the register takes the write
	task automatic set_mode(input logic [1:0] xs, input logic ts, input logic [1:0] op,
		input logic dp, input logic dm);
		bus(1'b1, 4'h0, {27'h0, op, ts, xs}, q);
		bus(1'b1, 4'h4, {30'h0, dm, dp}, q);
		@(posedge clk);
		@(negedge clk);
	endtask : set_mode

	task automatic t_term();
		logic [11:0] tbl [15] = '{12'h2e0, 12'h067, 12'h167, 12'he66, 12'h310, 12'h001,
			12'hb08, 12'h632, 12'h023, 12'h422, 12'ha26, 12'hd06, 12'h466, 12'h332,
			12'hc06};
		foreach (tbl[i])
		begin
			set_mode(tbl[i][11:10], tbl[i][9], tbl[i][8:7], tbl[i][6], tbl[i][5]);
			chk("enables", term, tbl[i][4:0]);
			bus(1'b0, 4'hc, 32'h0, q);
			chk("status enables", q[4:0], tbl[i][4:0]);
		end
	endtask : t_term

	task automatic t_rx(input logic [1:0] xs);
		logic [4:0] p;
		set_mode(xs, 1'b1, 2'b00, 1'b0, 1'b0);
		p = {hs_rx_bit, fs_rx_bit, hs_squelch, dm_se_rx, dp_se_rx};
		repeat (16)
		begin
			@(negedge clk);
			chk("rx bit", rx_bit, (xs == 2'b00) ? p[4] : p[3]);
			chk("rx valid", rx_valid, (xs == 2'b00) ? !p[2] : 1'b1);
			chk("line state", line_state, p[1:0]);
			p = {hs_rx_bit, fs_rx_bit, hs_squelch, dm_se_rx, dp_se_rx};
		end
	endtask : t_rx

	task automatic t_tx(input logic [1:0] xs, input logic [1:0] op, input logic [7:0] b,
		input int n, input logic [8:0] e);
		logic [8:0] got;
		set_mode(xs, xs[0], op, 1'b0, 1'b0);
		peer.bits_q.delete();
		@(posedge clk);
		tx_data <= b;
		tx_valid <= 1'b1;
		do @(posedge clk); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
		repeat (20) @(posedge clk);
		chk("fs dm idle", fs_tx_dm, 1'b0);
		got = 9'h000;
		foreach (peer.bits_q[i])
			got[i] = peer.bits_q[i];
		chk("tx bit count", peer.bits_q.size(), n);
		chk("tx bits", got, e);
	endtask : t_tx

	task automatic t_regs();
		bus(1'b1, 4'h8, 32'h65, q);
		@(posedge clk);
		@(negedge clk);
		chk("boost", boost, 3'h5);
		chk("sensitivity", sense, 3'h6);
		bus(1'b0, 4'h8, 32'h0, q);
		chk("comp readback", q, 32'h65);
		bus(1'b1, 4'h2, 32'hffffffff, q);
		bus(1'b0, 4'h2, 32'h0, q);
		chk("unmapped read", q, 32'h0);
	endtask : t_regs

	initial
	begin
		repeat (7) @(posedge clk);
		@(negedge clk);
		chk("hs drive in reset", hs_tx_oe, 1'b0);
		chk("fs drive in reset", fs_tx_oe, 1'b0);
		@(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0, q);
		chk("func ctrl reset", q, 32'h1);
		bus(1'b0, 4'h4, 32'h0, q);
		chk("otg ctrl reset", q, 32'h3);
		bus(1'b0, 4'h8, 32'h0, q);
		chk("comp reset", q, 32'h0);
		chk("enables after reset", term, 5'h06);
		t_term();
		t_rx(2'b00);
		t_rx(2'b01);
		t_tx(2'b00, 2'b00, 8'hff, 9, 9'h1bf);
		t_tx(2'b01, 2'b00, 8'ha5, 8, 9'h0a5);
		t_tx(2'b00, 2'b01, 8'h5a, 0, 9'h000);
		t_regs();
		end_sim();
	end
endmodule : tb
